// [hdl/cpsi_top.v]
// cpsi_top.v: core power state sideband, status mirrors, wait and sleep control
// assumes one 40 MHz clock, synchronous active-low reset, wake pins asynchronous
// Summary of operation
// - low-power request output mirrors status bit 27
// - exception-level output mirrors status bit 1
// - error-level output mirrors status bit 2
// - debug-mode output mirrors debug bit 30
// - exception in low power sets its bit
// - wait suspends clock, timer and wake inputs live
// - interrupt, nmi or reset leaves wait mode
// - sleep indicator asserted while in sleep
// - sleep only after bus and pipeline drain
// - debug mode from debug exception until return
// - soft-reset-enable deasserted while in debug mode
// - soft-reset-enable output is advisory only
// - static design keeps state with clock halted
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cpsi_defs.vh"
module cpsi_top #(
  parameter INT_WIDTH = 6,
  parameter TIMER_WIDTH = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [INT_WIDTH-1:0] int_pin,
  input wire nmi_pin,
  input wire reset_req_pin,
  input wire [7:0] bus_outstanding,
  input wire pipe_busy,
  output wire low_power_request_out,
  output wire exception_level_out,
  output wire error_level_out,
  output wire debug_mode_out,
  output wire soft_reset_enable_out,
  output reg sleep_out,
  output wire core_clk_en,
  output reg [TIMER_WIDTH-1:0] timer_count
);
  wire [INT_WIDTH+1:0] pins_sync;
  wire [INT_WIDTH-1:0] int_s;
  wire nmi_s;
  wire rst_req_s;
  reg [31:0] status_reg;
  reg [31:0] debug_reg;
  reg [1:0] state;
  reg [1:0] next_state;
  reg wait_pending;
  reg [15:0] wake_count;
  wire wake_event;
  wire cmd_wr;
  wire drained;

  // wake pins cross into clk before any logic sees them
  cpsi_sync #(
    .WIDTH(INT_WIDTH + 2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({reset_req_pin, nmi_pin, int_pin}),
    .sync_out(pins_sync)
  );
  assign int_s = pins_sync[INT_WIDTH-1:0];
  assign nmi_s = pins_sync[INT_WIDTH];
  assign rst_req_s = pins_sync[INT_WIDTH+1];

  assign low_power_request_out = status_reg[`CPSI_STATUS_RP_BIT];
  assign exception_level_out = status_reg[`CPSI_STATUS_EXL_BIT];
  assign error_level_out = status_reg[`CPSI_STATUS_ERL_BIT];
  assign debug_mode_out = debug_reg[`CPSI_DEBUG_DM_BIT];
  // only a hint to the system; nothing inside uses it
  assign soft_reset_enable_out = ~debug_reg[`CPSI_DEBUG_DM_BIT];

  assign cmd_wr = reg_wr && (reg_addr == `CPSI_ADDR_CMD);
  assign wake_event = (|int_s) | nmi_s | rst_req_s;
  assign drained = (bus_outstanding == 8'h00) && !pipe_busy;
  // the gated domain stops in sleep; this logic stays on clk
  assign core_clk_en = (state != `CPSI_ST_SLEEP);

  // status register: software writes, hardware events set levels
  always @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= `CPSI_STATUS_RESET;
    end else begin
      if (reg_wr && (reg_addr == `CPSI_ADDR_STATUS)) begin
        status_reg <= reg_wdata;
      end
      if (cmd_wr && reg_wdata[`CPSI_CMD_ERET_BIT]) begin
        status_reg[`CPSI_STATUS_EXL_BIT] <= 1'b0;
        status_reg[`CPSI_STATUS_ERL_BIT] <= 1'b0;
      end
      // hardware set wins over a same-cycle clear
      if (cmd_wr && reg_wdata[`CPSI_CMD_EXC_BIT]) begin
        status_reg[`CPSI_STATUS_EXL_BIT] <= 1'b1;
      end
      if ((cmd_wr && reg_wdata[`CPSI_CMD_ERR_BIT]) || rst_req_s || nmi_s) begin
        status_reg[`CPSI_STATUS_ERL_BIT] <= 1'b1;
      end
    end
  end

  // debug register: mode held from debug exception to debug return
  always @(posedge clk) begin
    if (!rst_n) begin
      debug_reg <= `CPSI_DEBUG_RESET;
    end else begin
      if (reg_wr && (reg_addr == `CPSI_ADDR_DEBUG)) begin
        debug_reg <= reg_wdata;
      end
      if (cmd_wr && reg_wdata[`CPSI_CMD_DRET_BIT]) begin
        debug_reg[`CPSI_DEBUG_DM_BIT] <= 1'b0;
      end
      if (cmd_wr && reg_wdata[`CPSI_CMD_DBGEXC_BIT]) begin
        debug_reg[`CPSI_DEBUG_DM_BIT] <= 1'b1;
      end
    end
  end

  // timer keeps running through sleep
  always @(posedge clk) begin
    if (!rst_n) begin
      timer_count <= {TIMER_WIDTH{1'b0}};
    end else begin
      timer_count <= timer_count + {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // wait sequencer: drain first, then sleep until a wake event
  always @* begin
    next_state = state;
    case (state)
      `CPSI_ST_RUN: begin
        if (wait_pending) begin
          next_state = `CPSI_ST_DRAIN;
        end
      end
      `CPSI_ST_DRAIN: begin
        if (wake_event) begin
          next_state = `CPSI_ST_RUN;
        end else if (drained) begin
          next_state = `CPSI_ST_SLEEP;
        end
      end
      `CPSI_ST_SLEEP: begin
        if (wake_event) begin
          next_state = `CPSI_ST_RUN;
        end
      end
      default: begin
        next_state = `CPSI_ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= `CPSI_ST_RUN;
      wait_pending <= 1'b0;
      sleep_out <= 1'b0;
      wake_count <= 16'h0000;
    end else begin
      state <= next_state;
      if (cmd_wr && reg_wdata[`CPSI_CMD_WAIT_BIT] && (state == `CPSI_ST_RUN)) begin
        wait_pending <= 1'b1;
      end else if (state != `CPSI_ST_RUN) begin
        wait_pending <= 1'b0;
      end
      sleep_out <= (next_state == `CPSI_ST_SLEEP);
      if ((state == `CPSI_ST_SLEEP) && wake_event) begin
        wake_count <= wake_count + 16'h0001;
      end
    end
  end

  // read port: data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CPSI_ADDR_STATUS: reg_rdata <= status_reg;
        `CPSI_ADDR_DEBUG: reg_rdata <= debug_reg;
        `CPSI_ADDR_STATE: reg_rdata <= {29'h0000_0000, sleep_out, state};
        `CPSI_ADDR_WAKECNT: reg_rdata <= {16'h0000, wake_count};
        `CPSI_ADDR_ID: reg_rdata <= `CPSI_ID_VALUE;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // cpsi_top
`default_nettype wire

// [hdl/cpsi_defs.vh]
// cpsi_defs.vh: constants for the core power state interface
// assumes inclusion by bare name from the design files
`ifndef CPSI_DEFS_VH
`define CPSI_DEFS_VH
// status register bit positions
`define CPSI_STATUS_RP_BIT 27
`define CPSI_STATUS_EXL_BIT 1
`define CPSI_STATUS_ERL_BIT 2
// debug control register bit position
`define CPSI_DEBUG_DM_BIT 30
// register offsets on the plain register port
`define CPSI_ADDR_STATUS 4'h0
`define CPSI_ADDR_DEBUG 4'h1
`define CPSI_ADDR_CMD 4'h2
`define CPSI_ADDR_STATE 4'h3
`define CPSI_ADDR_WAKECNT 4'h4
`define CPSI_ADDR_ID 4'h5
// command register bits (write one to act)
`define CPSI_CMD_WAIT_BIT 0
`define CPSI_CMD_EXC_BIT 1
`define CPSI_CMD_ERR_BIT 2
`define CPSI_CMD_DBGEXC_BIT 3
`define CPSI_CMD_DRET_BIT 4
`define CPSI_CMD_ERET_BIT 5
// reset values
`define CPSI_STATUS_RESET 32'h0000_0004
`define CPSI_DEBUG_RESET 32'h0000_0000
// identity value, arbitrary
`define CPSI_ID_VALUE 32'h0000_5A01
// state codes
`define CPSI_ST_RUN 2'h0
`define CPSI_ST_DRAIN 2'h1
`define CPSI_ST_SLEEP 2'h2
`endif

// [hdl/cpsi_sync.v]
// cpsi_sync.v: two flip-flop synchroniser for a vector of pin levels
// assumes pins are asynchronous to clk; first stage read only by second
`timescale 1ns/10ps
`default_nettype none
module cpsi_sync #(
  parameter WIDTH = 9
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // cpsi_sync
`default_nettype wire

// [tb/cpsi_checker.sv]
// cpsi_checker.sv: assertions on the power state sideband ports
// assumes binding to cpsi_top, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module cpsi_checker #(
  parameter TIMER_WIDTH = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire nmi_pin,
  input wire [7:0] bus_outstanding,
  input wire pipe_busy,
  input wire low_power_request_out,
  input wire exception_level_out,
  input wire debug_mode_out,
  input wire soft_reset_enable_out,
  input wire sleep_out,
  input wire core_clk_en,
  input wire [TIMER_WIDTH-1:0] timer_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ws = reg_wr && reg_addr == 4'h0;
  wire wc = reg_wr && reg_addr == 4'h2;
  a_rp_mirror: assert property (ws |=> low_power_request_out == $past(reg_wdata[27]))
    else $error("request mirror wrong");
  a_exl_mirror: assert property (ws |=> exception_level_out == $past(reg_wdata[1]))
    else $error("exception mirror wrong");
  a_dm_mirror: assert property (reg_wr && reg_addr == 4'h1 |=> debug_mode_out == $past(reg_wdata[30]))
    else $error("debug mirror wrong");
  a_exc_sets: assert property (wc && reg_wdata[1] |=> exception_level_out)
    else $error("exception not set");
  a_dbg_enter: assert property (wc && reg_wdata[3] |=> debug_mode_out && !soft_reset_enable_out)
    else $error("debug entry wrong");
  a_srst_advice: assert property (soft_reset_enable_out != debug_mode_out)
    else $error("soft reset hint wrong");
  a_sleep_gate: assert property (sleep_out != core_clk_en)
    else $error("clock gate disagrees with sleep");
  a_sleep_drain: assert property ($rose(sleep_out) |-> $past(bus_outstanding) == 8'h00 && !$past(pipe_busy))
    else $error("slept before drain");
  a_nmi_wake: assert property (sleep_out && nmi_pin |-> ##[1:4] !sleep_out)
    else $error("no wake on nmi");
  a_timer_live: assert property (!core_clk_en |=> timer_count == $past(timer_count) + 1'b1)
    else $error("timer stopped in sleep");
endmodule // cpsi_checker
bind cpsi_top cpsi_checker #(.TIMER_WIDTH(TIMER_WIDTH)) u_chk (.*);
`default_nettype wire

// [tb/cpsi_agent_model.sv]
// cpsi_agent_model.sv: system power and reset agent beside the core
// assumes the bench sets wake and hold levels at clock edges
`timescale 1ns/10ps
`default_nettype none
module cpsi_agent_model (
  input wire clk,
  input wire hold_busy,
  input wire [7:0] wake,
  input wire low_power_request_out,
  output logic [5:0] int_pin,
  output logic nmi_pin,
  output logic reset_req_pin,
  output logic [7:0] bus_outstanding,
  output logic pipe_busy,
  output logic slow_clock
);
  initial {slow_clock, bus_outstanding, pipe_busy, reset_req_pin, nmi_pin, int_pin} = 18'h00000;
  always @(posedge clk) begin
    slow_clock <= low_power_request_out;
    // traffic stays open while held, so sleep entry must wait on it
    bus_outstanding <= hold_busy ? 8'h03 : 8'h00;
    pipe_busy <= hold_busy;
    // hard reset passes whatever the soft reset hint says
    {reset_req_pin, nmi_pin, int_pin} <= wake;
  end
endmodule // cpsi_agent_model
`default_nettype wire

// [tb/test_core_power_state_interface.sv]
// test_core_power_state_interface.sv: self-checking bench for cpsi_top
// assumes the agent model on the far side and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module test_core_power_state_interface;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, hold_busy = 0, rd_d = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, v;
  logic [7:0] wake = 8'h00;
  wire [31:0] reg_rdata, timer_count;
  wire [5:0] int_pin;
  wire [7:0] bus_outstanding;
  wire nmi_pin, reset_req_pin, pipe_busy, lpr, exception_level_bit, error_level_bit, dm, sre, sleep_out, cke;
  logic [31:0] expq[$];
  int fail_count = 0, checks = 0;
  cpsi_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_pin(int_pin),
    .nmi_pin(nmi_pin), .reset_req_pin(reset_req_pin), .bus_outstanding(bus_outstanding),
    .pipe_busy(pipe_busy), .low_power_request_out(lpr), .exception_level_out(exception_level_bit),
    .error_level_out(error_level_bit), .debug_mode_out(dm), .soft_reset_enable_out(sre),
    .sleep_out(sleep_out), .core_clk_en(cke), .timer_count(timer_count));
  cpsi_agent_model agent (.clk(clk), .hold_busy(hold_busy), .wake(wake),
    .low_power_request_out(lpr), .int_pin(int_pin), .nmi_pin(nmi_pin),
    .reset_req_pin(reset_req_pin), .bus_outstanding(bus_outstanding),
    .pipe_busy(pipe_busy), .slow_clock());
  initial forever #12.5 clk = ~clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task wait_sleep(input logic val);
    for (int n = 0; n < 60 && sleep_out !== val; n++) @(posedge clk) #1;
    if (sleep_out !== val) begin
      fail_count++;
      final_report;
    end
  endtask
  // read data stands one cycle only, so it is taken at the next edge
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d && expq.size() > 0) check(reg_rdata, expq.pop_front());
  end
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    v = $urandom(32'h7497);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({lpr, exception_level_bit, error_level_bit, dm, sre, sleep_out}, 6'h0A);
    repeat (6) begin
      v = $urandom;
      wr(4'h0, v & 32'h0800_0006);
      wr(4'h1, v & 32'h4000_0000);
      check({lpr, exception_level_bit, error_level_bit, dm, sre}, {v[27], v[1], v[2], v[30], ~v[30]});
      rd(4'h0, v & 32'h0800_0006);
    end
    rd(4'hF, 32'h0);
    wr(4'h0, 32'h0800_0000);
    wr(4'h2, 32'h2);
    check(exception_level_bit, 1'b1);
    wr(4'h2, 32'h4);
    check(error_level_bit, 1'b1);
    wr(4'h2, 32'h20);
    check({exception_level_bit, error_level_bit}, 2'h0);
    wr(4'h2, 32'h8);
    check({dm, sre}, 2'h2);
    wr(4'h2, 32'h10);
    check({dm, sre, lpr}, 3'h3);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      hold_busy <= 1'b1;
      wr(4'h2, 32'h1);
      repeat (8) @(posedge clk);
      hold_busy <= 1'b0;
      #1;
      check(sleep_out, 1'b0);
      wait_sleep(1'b1);
      check(cke, 1'b0);
      v = timer_count;
      repeat (3) @(posedge clk);
      wake <= 8'h01 << ((i == 0) ? $urandom_range(5) : i + 5);
      #1;
      check(timer_count, v + 32'h3);
      wait_sleep(1'b0);
      check(cke, 1'b1);
      @(posedge clk);
      wake <= 8'h00;
      repeat (3) @(posedge clk);
    end
    // one wake counted per sleep; back in run with sleep low
    rd(4'h4, 32'h0000_0003);
    rd(4'h3, 32'h0000_0000);
    // identity value is arbitrary
    rd(4'h5, 32'h0000_5A01);
    repeat (3) @(posedge clk);
    final_report;
  end
endmodule // test_core_power_state_interface
`default_nettype wire
